/* src/pmcs_pkg.sv */
// Notes on behaviour
// R1: hold device reset until power-up delays expire
// R2: power-up timer runs only when disable_n zero
// R3: crystal modes count 1024 oscillator cycles first
// R4: pll mode adds 2 ms after crystal count
// R5: delays done sets primary_ready_flag, bit 3
// R6: cpu_ready_delay runs alongside; may be only delay
// R7: sleep drives clkout low; port modes free pins
// R8: seven modes: run, idle, sleep categories
// R9: idle_choice_bit bit 7, clock_origin_choice bits 1:0
// R10: 00 primary, 01 timer osc, 1x internal
// R11: new origin switches at once if source runs
// R12: sleep instruction: idle bit picks sleep or idle
// R13: no sleep: cpu and peripherals clocked
// R14: switch pauses two old plus three-four new cycles
// R15: three flags report the active clock source
// R16: internal primary may set both ready flags
// R17: each sleep uses idle bit as it stands
// R18: timer osc selection ignored unless enabled
// R19: clock_origin_choice cleared by every reset
// R20: idle exits by wake; bits kept; cpu delay
package pmcs_pkg;
    // register byte addresses
    localparam logic [11:0] OSC_CONTROL_ADDR = 12'h000;
    localparam logic [11:0] TIMER1_CONTROL_ADDR = 12'h004;
    localparam logic [11:0] STATUS_ADDR = 12'h008;
    localparam logic [11:0] CONFIG_ADDR = 12'h00c;
    // osc_control_reg fields
    localparam int IDLE_BIT = 7;
    localparam int PRIMARY_READY_BIT = 3;
    localparam int INTERNAL_STABLE_BIT = 2;
    // timer1_control_reg fields
    localparam int TIMER_ACTIVE_BIT = 6;
    localparam int TIMER_ENABLE_BIT = 3;
    localparam logic [7:0] OSC_CONTROL_RESET = 8'h00;
    // primary_osc_config encodings (4 bits)
    localparam logic [3:0] LOW_POWER_CRYSTAL_MODE = 4'h0;
    localparam logic [3:0] STD_CRYSTAL_MODE = 4'h1;
    localparam logic [3:0] FAST_CRYSTAL_MODE = 4'h2;
    localparam logic [3:0] FAST_CRYSTAL_PLL_MODE = 4'h6;
    localparam logic [3:0] OUTSIDE_CLOCK_MODE = 4'h4;
    localparam logic [3:0] OUTSIDE_CLOCK_PORT_MODE = 4'h5;
    localparam logic [3:0] RESISTOR_CAP_MODE = 4'h7;
    localparam logic [3:0] RESISTOR_CAP_PORT_MODE = 4'h3;
    localparam logic [3:0] INTERNAL_OSC_PORT_MODE = 4'h8;
    localparam logic [3:0] INTERNAL_OSC_CLKOUT_MODE = 4'h9;
    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int STARTUP_CYCLES = 1024;
    localparam int PLL_LOCK_US = 2000;
    localparam int PLL_LOCK_CYCLES = PLL_LOCK_US * (CLK_HZ / 1_000_000);
    localparam int POWER_UP_CYCLES = 8192;
    localparam int CPU_READY_CYCLES = 64;
    localparam int OLD_SRC_CYCLES = 2;
    localparam int NEW_SRC_CYCLES = 4;
    typedef enum logic [1:0] {
        PMCS_SRC_PRIMARY,
        PMCS_SRC_TIMER,
        PMCS_SRC_INTERNAL
    } pmcs_src_t;
    typedef enum logic [2:0] {
        PMCS_PRIMARY_RUN,
        PMCS_TIMER_OSC_RUN,
        PMCS_INTERNAL_RUN,
        PMCS_PRIMARY_IDLE,
        PMCS_TIMER_OSC_IDLE,
        PMCS_INTERNAL_IDLE,
        PMCS_SLEEP
    } pmcs_mode_t;
endpackage

/* src/pmcs_delay.sv */
`timescale 1ns/1ps
// one-shot down counter; done stays high from the end of the count until the next start
module pmcs_delay #(
    parameter int COUNT = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic start,
    input wire logic advance,
    output logic done_ff
);
    localparam int W = $clog2(COUNT + 1);
    logic [W-1:0] cnt_ff; // cycles left
    logic run_ff; // counting
    // restart on start, decrement on each advance while running
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= '0;
            run_ff <= 1'b0;
            done_ff <= 1'b0;
        end else if (start) begin
            cnt_ff <= W'(COUNT);
            run_ff <= 1'b1;
            done_ff <= 1'b0;
        end else if (run_ff && advance) begin
            if (cnt_ff <= W'(1)) begin
                run_ff <= 1'b0;
                done_ff <= 1'b1;
            end
            cnt_ff <= cnt_ff - W'(1);
        end
    end
endmodule

/* src/pmcs_top.sv */
`timescale 1ns/1ps
module pmcs_top #(
    parameter int POWER_UP_CYCLES = pmcs_pkg::POWER_UP_CYCLES,
    parameter int PLL_LOCK_CYCLES = pmcs_pkg::PLL_LOCK_CYCLES,
    parameter int CPU_READY_CYCLES = pmcs_pkg::CPU_READY_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [3:0] primary_osc_config,
    input wire logic power_up_timer_disable_n,
    input wire logic primary_osc_tick,
    input wire logic timer_osc_running,
    input wire logic internal_osc_stable,
    input wire logic sleep_exec,
    input wire logic wake_event,
    output logic device_reset_ff,
    output logic cpu_clk_en_ff,
    output logic periph_clk_en_ff,
    output logic [1:0] active_src_ff,
    output logic clkout_low_ff,
    output logic osc_pins_port_ff
);
    import pmcs_pkg::*;

    logic idle_choice_bit_ff; // sleep or idle on sleep instruction
    logic [1:0] clock_origin_choice_ff; // requested source
    logic timer_osc_enable_ff; // timer oscillator enable
    logic nxt_idle_choice_bit, nxt_timer_osc_enable; // after any write
    logic [1:0] nxt_clock_origin_choice; // after any write
    logic primary_ready_flag_ff;
    logic internal_stable_flag_ff;
    logic timer_osc_active_flag_ff;
    pmcs_mode_t mode_ff; // current power mode
    logic [2:0] switch_cnt_ff; // clock transition pause count
    logic switch_pending_ff; // source change under way
    logic [1:0] pending_src_ff;
    logic sleeping_ff; // any low-power mode
    logic cpu_wait_ff; // waiting on cpu ready delay after wake
    logic ph_addr_ff; // data phase valid
    logic ph_write_ff;
    logic [11:0] ph_addr_q_ff;
    logic por_done_ff; // one-shot start strobe issued
    logic pwr_done, ost_done, pll_done, cpu_done;
    logic need_ost, need_pll, delays_done;
    logic cpu_start;
    logic [1:0] req_src;

    // crystal modes need the start-up count
    assign need_ost = primary_osc_config == LOW_POWER_CRYSTAL_MODE ||
        primary_osc_config == STD_CRYSTAL_MODE ||
        primary_osc_config == FAST_CRYSTAL_MODE ||
        primary_osc_config == FAST_CRYSTAL_PLL_MODE; // [R3]
    assign need_pll = primary_osc_config == FAST_CRYSTAL_PLL_MODE; // [R4]

    // power-up timer, bypassed when disable_n is one
    pmcs_delay #(.COUNT(POWER_UP_CYCLES)) u_powerup (
        .hclk(hclk), .hresetn(hresetn),
        .start(!por_done_ff && !power_up_timer_disable_n), // [R2]
        .advance(1'b1), .done_ff(pwr_done));
    // start-up count on oscillator ticks
    pmcs_delay #(.COUNT(STARTUP_CYCLES)) u_startup (
        .hclk(hclk), .hresetn(hresetn),
        .start(!por_done_ff && need_ost), // [R3]
        .advance(primary_osc_tick), .done_ff(ost_done));
    // pll lock wait after the start-up count
    pmcs_delay #(.COUNT(PLL_LOCK_CYCLES)) u_pll (
        .hclk(hclk), .hresetn(hresetn),
        .start(!por_done_ff && need_pll), // [R4]
        .advance(ost_done), .done_ff(pll_done));
    // cpu ready delay, concurrent with the others
    assign cpu_start = !por_done_ff || (sleeping_ff && wake_event);
    pmcs_delay #(.COUNT(CPU_READY_CYCLES)) u_cpu (
        .hclk(hclk), .hresetn(hresetn),
        .start(cpu_start), // [R6] [R20]
        .advance(1'b1), .done_ff(cpu_done));

    assign delays_done = (pwr_done || power_up_timer_disable_n) &&
        (ost_done || !need_ost) && (pll_done || !need_pll);

    // start strobe latch, one cycle after reset release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) por_done_ff <= 1'b0;
        else por_done_ff <= 1'b1;
    end

    // device held in reset until delays and cpu ready are done
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) device_reset_ff <= 1'b1;
        else if (por_done_ff && delays_done && cpu_done)
            device_reset_ff <= 1'b0; // [R1] [R6]
    end

    // decode the requested source; 1x internal, 01 timer, 00 primary
    always_comb begin
        if (clock_origin_choice_ff[1]) req_src = 2'(PMCS_SRC_INTERNAL);
        else if (clock_origin_choice_ff[0]) req_src = 2'(PMCS_SRC_TIMER);
        else req_src = 2'(PMCS_SRC_PRIMARY); // [R10]
    end

    // source switch with glitch-free pause
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_src_ff <= 2'(PMCS_SRC_PRIMARY);
            pending_src_ff <= 2'(PMCS_SRC_PRIMARY);
            switch_pending_ff <= 1'b0;
            switch_cnt_ff <= 3'h0;
        end else if (switch_pending_ff) begin
            if (switch_cnt_ff == 3'h0) begin
                active_src_ff <= pending_src_ff;
                switch_pending_ff <= 1'b0;
            end else begin
                switch_cnt_ff <= switch_cnt_ff - 3'h1; // [R14]
            end
        end else if (req_src != active_src_ff && !device_reset_ff &&
            (req_src != 2'(PMCS_SRC_TIMER) || timer_osc_running) &&
            (req_src != 2'(PMCS_SRC_INTERNAL) || internal_osc_stable) &&
            (req_src != 2'(PMCS_SRC_PRIMARY) || delays_done)) begin
            pending_src_ff <= req_src; // [R11]
            switch_pending_ff <= 1'b1;
            switch_cnt_ff <= 3'(OLD_SRC_CYCLES + NEW_SRC_CYCLES - 1); // [R14]
        end
    end

    // power mode state: sleep instruction and wake
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_ff <= PMCS_PRIMARY_RUN;
            sleeping_ff <= 1'b0;
            cpu_wait_ff <= 1'b0;
        end else if (sleeping_ff && wake_event) begin
            sleeping_ff <= 1'b0; // [R20]
            cpu_wait_ff <= 1'b1;
        end else if (!sleeping_ff && sleep_exec && !device_reset_ff) begin
            sleeping_ff <= 1'b1; // [R12] [R17]
            if (!idle_choice_bit_ff) mode_ff <= PMCS_SLEEP;
            else begin
                unique case (active_src_ff)
                    2'(PMCS_SRC_TIMER): mode_ff <= PMCS_TIMER_OSC_IDLE;
                    2'(PMCS_SRC_INTERNAL): mode_ff <= PMCS_INTERNAL_IDLE;
                    default: mode_ff <= PMCS_PRIMARY_IDLE;
                endcase
            end
        end else if (!sleeping_ff) begin
            if (cpu_wait_ff && cpu_done) cpu_wait_ff <= 1'b0;
            unique case (active_src_ff)
                2'(PMCS_SRC_TIMER): mode_ff <= PMCS_TIMER_OSC_RUN;
                2'(PMCS_SRC_INTERNAL): mode_ff <= PMCS_INTERNAL_RUN;
                default: mode_ff <= PMCS_PRIMARY_RUN; // [R8] [R13]
            endcase
        end
    end

    // clock gating from mode and transition pause
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_clk_en_ff <= 1'b0;
            periph_clk_en_ff <= 1'b0;
        end else begin
            cpu_clk_en_ff <= !device_reset_ff && !sleeping_ff &&
                !cpu_wait_ff && !switch_pending_ff; // [R12] [R13]
            periph_clk_en_ff <= !device_reset_ff && !switch_pending_ff &&
                mode_ff != PMCS_SLEEP; // [R8]
        end
    end

    // oscillator pin behaviour: clkout low in sleep, pins freed in port modes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clkout_low_ff <= 1'b0;
            osc_pins_port_ff <= 1'b0;
        end else begin
            clkout_low_ff <= mode_ff == PMCS_SLEEP &&
                (primary_osc_config == RESISTOR_CAP_MODE ||
                 primary_osc_config == INTERNAL_OSC_CLKOUT_MODE ||
                 primary_osc_config == OUTSIDE_CLOCK_MODE); // [R7]
            osc_pins_port_ff <=
                primary_osc_config == RESISTOR_CAP_PORT_MODE ||
                primary_osc_config == OUTSIDE_CLOCK_PORT_MODE ||
                primary_osc_config == INTERNAL_OSC_PORT_MODE; // [R7]
        end
    end

    // status flags follow the source giving the clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            primary_ready_flag_ff <= 1'b0;
            internal_stable_flag_ff <= 1'b0;
            timer_osc_active_flag_ff <= 1'b0;
        end else if (mode_ff == PMCS_SLEEP) begin
            primary_ready_flag_ff <= 1'b0;
            internal_stable_flag_ff <= 1'b0;
            timer_osc_active_flag_ff <= 1'b0;
        end else begin
            primary_ready_flag_ff <= delays_done && !switch_pending_ff &&
                active_src_ff == 2'(PMCS_SRC_PRIMARY); // [R5] [R15]
            internal_stable_flag_ff <= internal_osc_stable &&
                !switch_pending_ff &&
                (active_src_ff == 2'(PMCS_SRC_INTERNAL) ||
                 (active_src_ff == 2'(PMCS_SRC_PRIMARY) &&
                  primary_osc_config[3])); // [R15] [R16]
            timer_osc_active_flag_ff <= !switch_pending_ff &&
                active_src_ff == 2'(PMCS_SRC_TIMER); // [R15]
        end
    end

    // ahb-lite address phase capture; always zero wait
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_addr_ff <= 1'b0;
            ph_write_ff <= 1'b0;
            ph_addr_q_ff <= 12'h000;
        end else if (hready) begin
            ph_addr_ff <= hsel && htrans[1];
            ph_write_ff <= hwrite;
            ph_addr_q_ff <= haddr;
        end
    end

    // next values of the writable bits; reads use them as well,
    // so a read right behind a write already sees the new value
    always_comb begin
        nxt_idle_choice_bit = idle_choice_bit_ff;
        nxt_clock_origin_choice = clock_origin_choice_ff;
        nxt_timer_osc_enable = timer_osc_enable_ff;
        if (ph_addr_ff && ph_write_ff) begin
            if (ph_addr_q_ff == OSC_CONTROL_ADDR) begin
                nxt_idle_choice_bit = hwdata[IDLE_BIT]; // [R9]
                if (hwdata[1:0] != 2'b01 || timer_osc_enable_ff)
                    nxt_clock_origin_choice = hwdata[1:0]; // [R18]
            end else if (ph_addr_q_ff == TIMER1_CONTROL_ADDR) begin
                nxt_timer_osc_enable = hwdata[TIMER_ENABLE_BIT];
            end
        end
    end

    // register writes; timer select refused when not enabled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idle_choice_bit_ff <= 1'b0;
            clock_origin_choice_ff <= 2'b00; // [R19]
            timer_osc_enable_ff <= 1'b0;
        end else begin
            idle_choice_bit_ff <= nxt_idle_choice_bit;
            clock_origin_choice_ff <= nxt_clock_origin_choice;
            timer_osc_enable_ff <= nxt_timer_osc_enable;
        end
    end

    // read data, registered so hrdata comes from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) hrdata <= 32'h0000_0000;
        else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= 32'h0000_0000;
            unique case (haddr)
                OSC_CONTROL_ADDR: begin
                    hrdata[IDLE_BIT] <= nxt_idle_choice_bit;
                    hrdata[PRIMARY_READY_BIT] <= primary_ready_flag_ff;
                    hrdata[INTERNAL_STABLE_BIT] <= internal_stable_flag_ff;
                    hrdata[1:0] <= nxt_clock_origin_choice; // [R9]
                end
                TIMER1_CONTROL_ADDR: begin
                    hrdata[TIMER_ACTIVE_BIT] <= timer_osc_active_flag_ff;
                    hrdata[TIMER_ENABLE_BIT] <= nxt_timer_osc_enable;
                end
                STATUS_ADDR: hrdata[2:0] <= mode_ff;
                CONFIG_ADDR: hrdata[3:0] <= primary_osc_config;
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // zero-wait slave, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // checks on the start-up delays
    a_reset_hold: assert property (@(posedge hclk) // [R1]
        disable iff (!hresetn) !delays_done |=> device_reset_ff)
        else $error("device left reset before delays done");
    a_pll_order: assert property (@(posedge hclk) // [R4]
        disable iff (!hresetn) pll_done |-> ost_done)
        else $error("pll wait ended before start-up count");
    a_ready_flag: assert property (@(posedge hclk) // [R5]
        disable iff (!hresetn) primary_ready_flag_ff |-> $past(delays_done))
        else $error("ready flag set before delays");
    a_cpu_ready: assert property (@(posedge hclk) // [R6]
        disable iff (!hresetn) cpu_clk_en_ff |-> $past(cpu_done))
        else $error("cpu clocked before ready delay");
    // checks on register writes, source switching, low power and flags
    a_timer_refuse: assert property (@(posedge hclk) // [R18]
        disable iff (!hresetn)
        (ph_addr_ff && ph_write_ff && ph_addr_q_ff == OSC_CONTROL_ADDR &&
         hwdata[1:0] == 2'b01 && !timer_osc_enable_ff)
        |=> $stable(clock_origin_choice_ff))
        else $error("timer source taken while disabled");
    a_switch_len: assert property (@(posedge hclk) // [R14]
        disable iff (!hresetn)
        $rose(switch_pending_ff) |-> switch_pending_ff [*6] ##1
        !switch_pending_ff)
        else $error("clock switch pause wrong length");
    a_switch_target: assert property (@(posedge hclk) // [R11]
        disable iff (!hresetn)
        $fell(switch_pending_ff) |-> active_src_ff == $past(pending_src_ff))
        else $error("switch landed on the wrong source");
    a_sleep_entry: assert property (@(posedge hclk) // [R17]
        disable iff (!hresetn)
        (!sleeping_ff && sleep_exec && !device_reset_ff &&
         !idle_choice_bit_ff) |=> mode_ff == PMCS_SLEEP)
        else $error("sleep instruction missed sleep mode");
    a_sleep_gate: assert property (@(posedge hclk) // [R12]
        disable iff (!hresetn) mode_ff == PMCS_SLEEP |=> !periph_clk_en_ff)
        else $error("peripheral clock running in sleep");
    a_idle_periph: assert property (@(posedge hclk) // [R12]
        disable iff (!hresetn)
        (sleeping_ff && mode_ff != PMCS_SLEEP && !switch_pending_ff)
        |=> periph_clk_en_ff)
        else $error("peripheral clock stopped in idle");
    a_idle_cpu: assert property (@(posedge hclk) // [R12]
        disable iff (!hresetn) sleeping_ff |=> !cpu_clk_en_ff)
        else $error("cpu clocked in low power mode");
    a_wake_hold: assert property (@(posedge hclk) // [R20]
        disable iff (!hresetn) sleeping_ff && !wake_event |=> sleeping_ff)
        else $error("low power mode left without wake");
    a_clkout_sleep: assert property (@(posedge hclk) // [R7]
        disable iff (!hresetn) clkout_low_ff |-> $past(mode_ff == PMCS_SLEEP))
        else $error("clock-out forced low outside sleep");
    a_one_flag: assert property (@(posedge hclk) // [R15]
        disable iff (!hresetn)
        !(timer_osc_active_flag_ff && primary_ready_flag_ff))
        else $error("timer and primary flags both set");
    a_sleep_flags: assert property (@(posedge hclk) // [R15]
        disable iff (!hresetn) mode_ff == PMCS_SLEEP |=>
        !primary_ready_flag_ff && !timer_osc_active_flag_ff)
        else $error("status flags set in sleep");
    c_sleep: cover property (@(posedge hclk) mode_ff == PMCS_SLEEP);
    c_idle: cover property (@(posedge hclk) mode_ff == PMCS_INTERNAL_IDLE);
    c_switch: cover property (@(posedge hclk) $fell(switch_pending_ff));
    c_wake: cover property (@(posedge hclk) $fell(sleeping_ff));
    c_timer_run: cover property (@(posedge hclk) mode_ff == PMCS_TIMER_OSC_RUN);
endmodule

/* tb/pmcs_cpu_model.sv */
`timescale 1ns/1ps
// stand-in for the core and the primary crystal on the far side
module pmcs_cpu_model (
    input wire logic hclk,
    input wire logic cpu_clk_en_ff,
    output logic primary_osc_tick,
    output logic sleep_exec,
    output logic wake_event
);
    // everything quiet at time zero
    initial begin
        primary_osc_tick = 1'b0;
        sleep_exec = 1'b0;
        wake_event = 1'b0;
    end

    // crystal ticks every other bus clock, so a start-up count
    // costs twice its tick count in bus cycles
    always @(posedge hclk) begin
        primary_osc_tick <= ~primary_osc_tick;
    end

    // a halted core cannot execute the sleep instruction
    task sleep_cmd();
        do @(posedge hclk); while (cpu_clk_en_ff !== 1'b1);
        sleep_exec <= 1'b1;
        @(posedge hclk);
        sleep_exec <= 1'b0;
    endtask

    // one-cycle interrupt or watchdog wake
    task wake_cmd();
        @(posedge hclk);
        wake_event <= 1'b1;
        @(posedge hclk);
        wake_event <= 1'b0;
    endtask
endmodule

/* tb/pmcs_bench.sv */
`timescale 1ns/1ps
module pmcs_bench;
    import pmcs_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [11:0] haddr;
    logic [1:0] htrans, active_src_ff;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rdv;
    logic [3:0] primary_osc_config;
    logic power_up_timer_disable_n, primary_osc_tick, timer_osc_running;
    logic internal_osc_stable, sleep_exec, wake_event, device_reset_ff;
    logic cpu_clk_en_ff, periph_clk_en_ff, clkout_low_ff, osc_pins_port_ff;
    int err_total, compares, n;

    // short counts keep the run brief
    pmcs_top #(
        .POWER_UP_CYCLES(16),
        .PLL_LOCK_CYCLES(8),
        .CPU_READY_CYCLES(4)
    ) i_pmcs_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata),
        .primary_osc_config(primary_osc_config),
        .power_up_timer_disable_n(power_up_timer_disable_n),
        .primary_osc_tick(primary_osc_tick),
        .timer_osc_running(timer_osc_running),
        .internal_osc_stable(internal_osc_stable),
        .sleep_exec(sleep_exec), .wake_event(wake_event),
        .device_reset_ff(device_reset_ff), .cpu_clk_en_ff(cpu_clk_en_ff),
        .periph_clk_en_ff(periph_clk_en_ff), .active_src_ff(active_src_ff),
        .clkout_low_ff(clkout_low_ff), .osc_pins_port_ff(osc_pins_port_ff)
    );

    pmcs_cpu_model i_pmcs_cpu_model (
        .hclk(hclk), .cpu_clk_en_ff(cpu_clk_en_ff),
        .primary_osc_tick(primary_osc_tick),
        .sleep_exec(sleep_exec), .wake_event(wake_event)
    );

    // single slave: its ready is the bus ready
    assign hready = hreadyout;

    // 20 mhz bus clock
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    // compare and tally
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // one single word transfer; read data lands in rdv
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'b010;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rdv = hrdata;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task rdc(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rdv, e);
    endtask

    // 0 reset hold, 1 cpu clock, 2 active source
    function logic [1:0] pick(input int s);
        if (s == 0) return {1'b0, device_reset_ff};
        if (s == 1) return {1'b0, cpu_clk_en_ff};
        return active_src_ff;
    endfunction

    // settled sampling; n counts the edges waited
    task wait_for(input int s, input logic [1:0] v);
        n = 0;
        do begin
            @(posedge hclk);
            #1;
            n++;
        end while (pick(s) !== v);
    endtask

    // reset for four cycles with a given configuration
    task boot(input logic [3:0] cfg, input logic dn);
        @(posedge hclk);
        hresetn <= 1'b0;
        primary_osc_config <= cfg;
        power_up_timer_disable_n <= dn;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        wait_for(0, 2'b00);
    endtask

    task sleep_now();
        i_pmcs_cpu_model.sleep_cmd();
        wait_for(1, 2'b00);
    endtask

    task end_sim();
        if (err_total == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // hang guard, far beyond the longest boot
    initial begin
        repeat (20000) @(posedge hclk);
        err_total++;
        end_sim();
    end

    // main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 12'h000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        primary_osc_config = FAST_CRYSTAL_PLL_MODE;
        power_up_timer_disable_n = 1'b1;
        timer_osc_running = 1'b1;
        internal_osc_stable = 1'b0;
        err_total = 0;
        compares = 0;
        boot(FAST_CRYSTAL_PLL_MODE, 1'b1);
        chk(32'(n >= 2056), 32'h1);
        rdc(OSC_CONTROL_ADDR, 32'h08);
        chk({hreadyout, hresp}, 32'h2);
        chk({cpu_clk_en_ff, periph_clk_en_ff, active_src_ff}, 32'hc);
        rdc(STATUS_ADDR, 32'(PMCS_PRIMARY_RUN));
        // timer oscillator not enabled: selection must not stick
        wr(OSC_CONTROL_ADDR, 32'h01);
        repeat (10) @(posedge hclk);
        rdc(OSC_CONTROL_ADDR, 32'h08);
        chk(active_src_ff, 32'h0);
        wr(TIMER1_CONTROL_ADDR, 32'h08);
        wr(OSC_CONTROL_ADDR, 32'h01);
        wait_for(2, 2'b01);
        chk(32'(n >= 5 && n <= 7), 32'h1);
        rdc(TIMER1_CONTROL_ADDR, 32'h48);
        rdc(OSC_CONTROL_ADDR, 32'h01);
        rdc(STATUS_ADDR, 32'(PMCS_TIMER_OSC_RUN));
        internal_osc_stable <= 1'b1;
        wr(OSC_CONTROL_ADDR, 32'h02);
        wait_for(2, 2'b10);
        chk(32'(n >= 5 && n <= 7), 32'h1);
        rdc(OSC_CONTROL_ADDR, 32'h06);
        rdc(TIMER1_CONTROL_ADDR, 32'h08);
        // 11 is internal as well, and idle bit set
        wr(OSC_CONTROL_ADDR, 32'h83);
        repeat (10) @(posedge hclk);
        rdc(OSC_CONTROL_ADDR, 32'h87);
        chk(active_src_ff, 32'h2);
        sleep_now();
        chk(periph_clk_en_ff, 32'h1);
        rdc(STATUS_ADDR, 32'(PMCS_INTERNAL_IDLE));
        i_pmcs_cpu_model.wake_cmd();
        wait_for(1, 2'b01);
        chk(32'(n >= 3), 32'h1);
        rdc(OSC_CONTROL_ADDR, 32'h87);
        chk(active_src_ff, 32'h2);
        // idle bit cleared: the next sleep stops everything
        wr(OSC_CONTROL_ADDR, 32'h03);
        sleep_now();
        chk({periph_clk_en_ff, clkout_low_ff}, 32'h0);
        rdc(STATUS_ADDR, 32'(PMCS_SLEEP));
        rdc(OSC_CONTROL_ADDR, 32'h03);
        i_pmcs_cpu_model.wake_cmd();
        wait_for(1, 2'b01);
        rdc(STATUS_ADDR, 32'(PMCS_INTERNAL_RUN));
        rdc(12'h010, 32'h0);
        // internal block as primary source
        boot(INTERNAL_OSC_CLKOUT_MODE, 1'b1);
        rdc(OSC_CONTROL_ADDR, 32'h0c);
        sleep_now();
        chk({clkout_low_ff, osc_pins_port_ff}, 32'h2);
        // outside clock, power-up timer on then off
        for (int i = 0; i < 2; i++) begin
            boot(OUTSIDE_CLOCK_PORT_MODE, i[0]);
            chk(32'(n >= 16 && n < 1024), 32'(i == 0));
            sleep_now();
            chk({clkout_low_ff, osc_pins_port_ff}, 32'h1);
        end
        end_sim();
    end
endmodule
